// ---- design/csv_core_regs.svh ----
`ifndef CSV_CORE_REGS_SVH
`define CSV_CORE_REGS_SVH
`define CSV_OFF_CTRL 8'h00
`define CSV_OFF_SP 8'h04
`define CSV_OFF_ST0 8'h08
`define CSV_OFF_ST1 8'h0C
`define CSV_OFF_TREG 8'h10
`define CSV_OFF_WADDR 8'h14
`define CSV_OFF_WDATA 8'h18
`define CSV_OFF_WCTRL 8'h1C
`define CSV_OFF_ISTAT 8'h20
`define CSV_OFF_IMASK 8'h24
`define CSV_OFF_VEC 8'h28
`define CSV_OFF_STATE 8'h2C
`define CSV_CTRL_RESUME 0
`define CSV_CTRL_HALT 1
`define CSV_ST0_TC 0
`define CSV_ST0_V 1
`define CSV_ST0_Z 2
`define CSV_ST1_SPA 0
`define CSV_ST1_VECTOR_LOCATION_SELECT 1
`define CSV_WCTRL_EN 0
`define CSV_WCTRL_DATA 1
`define CSV_EV_WATCH 0
`define CSV_EV_TRAP 1
`define CSV_EV_OVF 2
`define CSV_EV_IGNORED 3
`define CSV_VEC_LOW 22'h000000
`define CSV_VEC_HIGH 22'h3FFFC0
`define CSV_RESP_OKAY 2'h0
`define CSV_RESP_SLVERR 2'h2
`endif

// ---- design/csv_pkg.sv ----
package csv_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_PUSH = 4'h1, OP_POP = 4'h2, OP_ASP = 4'h3,
    OP_ASR = 4'h4, OP_LSL = 4'h5, OP_LSR = 4'h6, OP_SFR = 4'h7,
    OP_BIT_TEST_INSTR = 4'h8, OP_NORMALIZE_INSTR = 4'h9, OP_ALU = 4'hA, OP_TRAP = 4'hB,
    OP_STORE = 4'hC
  } csv_op_e;
  typedef enum logic [2:0] {
    PH_F1 = 3'h0, PH_F2 = 3'h1, PH_D1 = 3'h2, PH_D2 = 3'h3,
    PH_R1 = 3'h4, PH_R2 = 3'h5, PH_EX = 3'h6, PH_WR = 3'h7
  } csv_phase_e;
  typedef struct packed {
    logic busy;
    csv_phase_e phase;
    csv_op_e op;
    logic [31:0] opnd;
    logic [3:0] bitsel;
    logic [21:0] oaddr;
    logic ovf;
    logic [15:0] sp;
    logic tc;
    logic v;
    logic z;
    logic stack_align_flag;
    logic vector_location_select;
    logic [15:0] treg;
    logic [31:0] shres;
    logic [15:0] popd;
    logic halted;
    logic [21:0] vec_addr;
    logic vec_pulse;
    logic [21:0] waddr;
    logic [15:0] wdata_cmp;
    logic wen;
    logic wdat;
    logic [3:0] istat;
    logic [3:0] imask;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } csv_state_s;
endpackage

// ---- design/csv_core.sv ----
// Function
// - The stack top pointer is 16 bits wide and every stack access lands in the first 64K data words.
// - The stack top pointer always holds the next free stack slot.
// - The stack align flag is 1 exactly when the align-stack op had to bump the pointer to even.
// - While halted by the emulator every interrupt, reset and NMI included, is ignored until resume.
// - Register-form shifts take their count from the low four bits of the multiplicand register.
// - The test result flag takes the outcome of the bit-test and normalize ops.
// - Twelve user trap vectors exist and only the trap op reaches them, never a hardware line.
// - The overflow flag is set on overflow and otherwise keeps its value.
// - Vector select 0 puts vectors in the lowest 64 program words, 1 in the highest 64 of 22 bits.
// - The zero flag is set when a result equals zero.
// - A write whose address, or address and data, matches the watchpoint halts the core into debug-halt.
// - Test logic resets on a low test reset or the TAP reset state, apart from the CPU reset.
// - In the last of eight phases a store presents destination address and data together.
// - A memory that is not ready makes the core spend whole idle wait cycles.
// - Memory words moved by the core are 16 bits wide.
// - A wait request in fetch 1, read 1 or write stalls that part of the pipeline.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
`include "csv_core_regs.svh"
module csv_core #(
  parameter int USER_FIRST = 20,
  parameter int USER_COUNT = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic op_valid,
  output logic op_ready,
  input wire csv_pkg::csv_op_e op_kind,
  input wire logic [31:0] op_data,
  input wire logic [3:0] op_bit,
  input wire logic [21:0] op_addr,
  input wire logic op_overflow,
  input wire logic prog_ready,
  output logic [21:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ready,
  output logic wait_state,
  output logic [15:0] pop_data,
  output logic [31:0] shift_result,
  input wire logic hw_int_valid,
  input wire logic [4:0] hw_int_num,
  output logic vec_valid,
  output logic [21:0] vec_addr,
  input wire logic halt_req,
  input wire logic run_req,
  output logic halted,
  input wire logic trst_n,
  input wire logic tap_tlr,
  output logic test_logic_reset
);
  if (USER_COUNT != 12 || USER_FIRST < 1 || USER_FIRST + USER_COUNT > 32) begin : g_bad
    $error("csv_core: user trap range does not fit 32 vectors");
  end

  csv_pkg::csv_state_s r, n;
  logic need_rd, need_wr, stall, fire, watch_hit, trap_ok;
  logic [3:0] ev, clr;
  logic [21:0] vbase;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `CSV_OFF_STATE;
  endfunction

  function automatic logic in_user(input logic [4:0] num);
    return int'(num) >= USER_FIRST && int'(num) < USER_FIRST + USER_COUNT;
  endfunction

  function automatic logic [31:0] shifter(input csv_pkg::csv_op_e op, input logic [31:0] val,
                                          input logic [3:0] cnt);
    logic [15:0] lo;
    lo = val[15:0];
    unique case (op)
      csv_pkg::OP_ASR: return {16'h0000, 16'($signed(lo) >>> cnt)};
      csv_pkg::OP_LSL: return {16'h0000, 16'(lo << cnt)};
      csv_pkg::OP_LSR: return {16'h0000, 16'(lo >> cnt)};
      default: return 32'($signed(val) >>> cnt);
    endcase
  endfunction

  assign need_rd = r.op == csv_pkg::OP_POP;
  assign need_wr = r.op == csv_pkg::OP_PUSH || r.op == csv_pkg::OP_STORE;
  // Only fetch 1, read 1 and write listen to readiness; the other phases never wait.
  assign stall = r.busy && ((r.phase == csv_pkg::PH_F1 && !prog_ready) ||
                 (r.phase == csv_pkg::PH_R1 && need_rd && !mem_ready) ||
                 (r.phase == csv_pkg::PH_WR && need_wr && !mem_ready));
  assign op_ready = !r.busy && !r.halted;
  assign fire = op_valid && op_ready;
  assign mem_re = r.busy && r.phase == csv_pkg::PH_R1 && need_rd;
  assign mem_we = r.busy && r.phase == csv_pkg::PH_WR && need_wr;
  // Stack addresses carry zero upper bits, so the stack stays in the first 64K words.
  assign mem_addr = (r.op == csv_pkg::OP_STORE) ? r.oaddr : {6'h00, r.sp};
  assign mem_wdata = r.opnd[15:0];
  assign wait_state = stall;
  assign watch_hit = r.wen && mem_addr == r.waddr && (!r.wdat || mem_wdata == r.wdata_cmp);
  assign vbase = r.vector_location_select ? `CSV_VEC_HIGH : `CSV_VEC_LOW;
  // Trap numbers whose low four bits fall outside 1 to 12 raise nothing, so a stray operand never lands on a line vector.
  assign trap_ok = r.opnd[3:0] != 4'h0 && int'(r.opnd[3:0]) <= USER_COUNT;
  assign test_logic_reset = !trst_n || tap_tlr;

  always_comb begin
    n = r;
    ev = 4'h0;
    clr = 4'h0;
    n.vec_pulse = 1'b0;
    if (s_axi_awvalid && !r.aw_got && !r.bvalid) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_got && !r.bvalid) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(r.awaddr) ? `CSV_RESP_OKAY : `CSV_RESP_SLVERR;
      case (r.awaddr)
        `CSV_OFF_CTRL: begin
          if (r.wstrb[0] && r.wdata[`CSV_CTRL_RESUME]) n.halted = 1'b0;
          if (r.wstrb[0] && r.wdata[`CSV_CTRL_HALT]) n.halted = 1'b1;
        end
        // Only the low half of a bus write reaches the 16-bit stack pointer.
        `CSV_OFF_SP: n.sp = 16'(wmerge({16'h0000, r.sp}, r.wdata, r.wstrb));
        `CSV_OFF_ST0: if (r.wstrb[0]) begin
          n.tc = r.wdata[`CSV_ST0_TC];
          n.v = r.wdata[`CSV_ST0_V];
          n.z = r.wdata[`CSV_ST0_Z];
        end
        `CSV_OFF_ST1: if (r.wstrb[0]) n.vector_location_select = r.wdata[`CSV_ST1_VECTOR_LOCATION_SELECT];
        `CSV_OFF_TREG: n.treg = 16'(wmerge({16'h0000, r.treg}, r.wdata, r.wstrb));
        `CSV_OFF_WADDR: n.waddr = 22'(wmerge({10'h000, r.waddr}, r.wdata, r.wstrb));
        `CSV_OFF_WDATA: n.wdata_cmp = 16'(wmerge({16'h0000, r.wdata_cmp}, r.wdata, r.wstrb));
        `CSV_OFF_WCTRL: if (r.wstrb[0]) begin
          n.wen = r.wdata[`CSV_WCTRL_EN];
          n.wdat = r.wdata[`CSV_WCTRL_DATA];
        end
        `CSV_OFF_ISTAT: if (r.wstrb[0]) clr = r.wdata[3:0];
        `CSV_OFF_IMASK: if (r.wstrb[0]) n.imask = r.wdata[3:0];
        default: ;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = mapped(s_axi_araddr) ? `CSV_RESP_OKAY : `CSV_RESP_SLVERR;
      case (s_axi_araddr)
        `CSV_OFF_SP: n.rdata = {16'h0000, r.sp};
        `CSV_OFF_ST0: n.rdata = {29'h0, r.z, r.v, r.tc};
        `CSV_OFF_ST1: n.rdata = {30'h0, r.vector_location_select, r.stack_align_flag};
        `CSV_OFF_TREG: n.rdata = {16'h0000, r.treg};
        `CSV_OFF_WADDR: n.rdata = {10'h000, r.waddr};
        `CSV_OFF_WDATA: n.rdata = {16'h0000, r.wdata_cmp};
        `CSV_OFF_WCTRL: n.rdata = {30'h0, r.wdat, r.wen};
        `CSV_OFF_ISTAT: n.rdata = {28'h0, r.istat};
        `CSV_OFF_IMASK: n.rdata = {28'h0, r.imask};
        `CSV_OFF_VEC: n.rdata = {10'h000, r.vec_addr};
        `CSV_OFF_STATE: n.rdata = {26'h0, r.halted, r.phase, r.busy, test_logic_reset};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (run_req) n.halted = 1'b0;
    if (halt_req) n.halted = 1'b1;
    if (fire) begin
      n.busy = 1'b1;
      n.phase = csv_pkg::PH_F1;
      n.op = op_kind;
      n.opnd = op_data;
      n.bitsel = op_bit;
      n.oaddr = op_addr;
      n.ovf = op_overflow;
    end else if (r.busy && !stall) begin
      n.phase = csv_pkg::csv_phase_e'(r.phase + 3'h1);
      unique case (r.phase)
        csv_pkg::PH_D2: if (need_rd) n.sp = r.sp - 16'h0001;
        csv_pkg::PH_R1: if (need_rd) n.popd = mem_rdata;
        csv_pkg::PH_EX: begin
          unique case (r.op)
            csv_pkg::OP_ASR, csv_pkg::OP_LSL, csv_pkg::OP_LSR, csv_pkg::OP_SFR: begin
              n.shres = shifter(r.op, r.opnd, r.treg[3:0]);
              n.z = n.shres == 32'h0000_0000;
            end
            csv_pkg::OP_BIT_TEST_INSTR: n.tc = r.opnd[r.bitsel];
            // Normalize reports an accumulator that is zero or already normalized.
            csv_pkg::OP_NORMALIZE_INSTR: n.tc = r.opnd == 32'h0 || r.opnd[31] != r.opnd[30];
            csv_pkg::OP_ALU: begin
              n.z = r.opnd[15:0] == 16'h0000;
              if (r.ovf) begin
                n.v = 1'b1;
                ev[`CSV_EV_OVF] = 1'b1;
              end
            end
            csv_pkg::OP_ASP: begin
              n.stack_align_flag = r.sp[0];
              if (r.sp[0]) n.sp = r.sp + 16'h0001;
            end
            csv_pkg::OP_TRAP: if (trap_ok) begin
              n.vec_pulse = 1'b1;
              n.vec_addr = vbase + 22'({USER_FIRST[4:0] + {1'b0, r.opnd[3:0]} - 5'h01, 1'b0});
              ev[`CSV_EV_TRAP] = 1'b1;
            end
            default: ;
          endcase
        end
        csv_pkg::PH_WR: begin
          n.busy = 1'b0;
          if (r.op == csv_pkg::OP_PUSH) n.sp = r.sp + 16'h0001;
          if (need_wr && watch_hit) begin
            n.halted = 1'b1;
            ev[`CSV_EV_WATCH] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // A trap issued in the same cycle wins the vector port; the hardware request is dropped.
    if (hw_int_valid && !n.vec_pulse) begin
      if (r.halted) begin
        ev[`CSV_EV_IGNORED] = 1'b1;
      end else if (!in_user(hw_int_num)) begin
        n.vec_pulse = 1'b1;
        n.vec_addr = vbase + {16'h0000, hw_int_num, 1'b0};
      end
    end
    if (test_logic_reset) begin
      n.wen = 1'b0;
      n.wdat = 1'b0;
      n.waddr = 22'h0;
      n.wdata_cmp = 16'h0000;
    end
    // An event landing with its clear keeps the bit set.
    n.istat = (r.istat & ~clr) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign irq = |(r.istat & r.imask);
  assign pop_data = r.popd;
  assign shift_result = r.shres;
  assign vec_valid = r.vec_pulse;
  assign vec_addr = r.vec_addr;
  assign halted = r.halted;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pop_stack_addr: assert property (mem_re |-> mem_addr == {6'h00, r.sp})
    else $error("pop read off the stack pointer");
  a_push_advance: assert property (mem_we && mem_ready && r.op == csv_pkg::OP_PUSH
    && !(r.aw_got && r.w_got) |=> r.sp == $past(r.sp) + 16'h0001)
    else $error("push did not advance pointer");
  a_pop_retreat: assert property (r.busy && !stall && need_rd
    && r.phase == csv_pkg::PH_D2 && !(r.aw_got && r.w_got)
    |=> r.sp == $past(r.sp) - 16'h0001 && mem_re)
    else $error("pop did not retreat before read");
  a_align_flag: assert property (r.busy && !stall && r.op == csv_pkg::OP_ASP
    && r.phase == csv_pkg::PH_EX |=> r.stack_align_flag == $past(r.sp[0]))
    else $error("align flag wrong");
  a_halt_ignore: assert property (r.halted && hw_int_valid
    && !(r.busy && r.op == csv_pkg::OP_TRAP && r.phase == csv_pkg::PH_EX) |=> !vec_valid)
    else $error("interrupt taken while halted");
  a_shift_count: assert property (r.busy && !stall && r.op == csv_pkg::OP_LSL
    && r.phase == csv_pkg::PH_EX
    |=> shift_result[15:0] == 16'($past(r.opnd[15:0]) << $past(r.treg[3:0])))
    else $error("shift count not from multiplicand");
  a_bit_test_instr_flag: assert property (r.busy && !stall && r.op == csv_pkg::OP_BIT_TEST_INSTR
    && r.phase == csv_pkg::PH_EX && !(r.aw_got && r.w_got)
    |=> r.tc == $past(r.opnd[r.bitsel]))
    else $error("test flag wrong");
  a_no_hw_user: assert property (hw_int_valid && in_user(hw_int_num) && !r.halted
    && !(r.busy && r.op == csv_pkg::OP_TRAP && r.phase == csv_pkg::PH_EX) |=> !vec_valid)
    else $error("hardware reached a user trap");
  a_v_sticky: assert property ($past(r.v) && !$past(r.aw_got && r.w_got) |-> r.v)
    else $error("overflow flag cleared");
  a_vector_base: assert property (vec_valid
    |-> vec_addr[21:6] == (r.vector_location_select ? 16'hFFFF : 16'h0000))
    else $error("vector outside mapped block");
  a_watch_halt: assert property (mem_we && mem_ready && watch_hit
    |=> halted ##1 !op_ready)
    else $error("watchpoint did not halt");
  a_test_reset: assert property (test_logic_reset |=> !r.wen)
    else $error("test reset left watchpoint armed");
  a_wait_hold: assert property (stall |=> r.phase == $past(r.phase) && r.busy)
    else $error("phase moved during wait");
  a_write_phase: assert property (mem_we |-> r.phase == csv_pkg::PH_WR && !mem_re)
    else $error("write outside write phase");

  c_push: cover property (mem_we && mem_ready && r.op == csv_pkg::OP_PUSH);
  c_pop_wait: cover property (mem_re && !mem_ready ##1 mem_re && mem_ready);
  c_trap: cover property (vec_valid && r.op == csv_pkg::OP_TRAP);
  c_watch: cover property (mem_we && mem_ready && watch_hit);
endmodule

// ---- bench/csv_mem_model.sv ----
`timescale 1ns/100ps
module csv_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [21:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [3:0] lat,
  output logic [15:0] mem_rdata,
  output logic mem_ready,
  output logic prog_ready
);
  logic [15:0] mem [0:255];
  logic [3:0] wcnt;
  logic [21:0] last_wa;
  logic tog;
  // Outside a ready cycle the bus shows a pattern that changes every cycle.
  assign mem_rdata = mem_ready ? mem[mem_addr[7:0]] : {8{tog, ~tog}};
  assign prog_ready = !(lat != 4'h0 && tog);
  always_ff @(posedge aclk) begin
    tog <= aresetn ? ~tog : 1'b0;
    if (!aresetn) begin
      wcnt <= 4'h0;
      mem_ready <= 1'b0;
    end else if ((mem_we || mem_re) && !mem_ready) begin
      if (wcnt >= lat) begin
        mem_ready <= 1'b1;
        wcnt <= 4'h0;
      end else begin
        wcnt <= wcnt + 4'h1;
      end
    end else begin
      mem_ready <= 1'b0;
    end
    if (mem_we && mem_ready) begin
      mem[mem_addr[7:0]] <= mem_wdata;
      last_wa <= mem_addr;
    end
  end
endmodule

// ---- bench/cpu_status_stack_vector_logic_tb_top.sv ----
`timescale 1ns/100ps
`include "csv_core_regs.svh"
module cpu_status_stack_vector_logic_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, shift_result, op_data = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF, op_bit = 4'h0, lat = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, op_ready, mem_we, mem_re, wait_state, vec_valid, halted;
  logic test_logic_reset, mem_ready, prog_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [21:0] mem_addr, vec_addr, op_addr = 22'h0, base;
  logic [15:0] mem_wdata, mem_rdata, pop_data, d0, d1;
  logic op_valid = 0, op_overflow = 0, hw_int_valid = 0, halt_req = 0, run_req = 0;
  logic trst_n = 1, tap_tlr = 0;
  csv_pkg::csv_op_e op_kind = csv_pkg::OP_NOP;
  csv_pkg::csv_op_e kinds [4] = '{csv_pkg::OP_ASR, csv_pkg::OP_LSL, csv_pkg::OP_LSR,
    csv_pkg::OP_SFR};
  logic [7:0] rst_regs [5] = '{`CSV_OFF_SP, `CSV_OFF_ST0, `CSV_OFF_ST1, `CSV_OFF_ISTAT,
    `CSV_OFF_IMASK};
  logic [31:0] sh_in [4] = '{32'h40, 32'h1, 32'h80, 32'h100};
  logic [31:0] sh_exp [4] = '{32'h8, 32'h8, 32'h10, 32'h20};
  logic [4:0] hw_int_num = 5'h00;
  int seed = 26221, cyc = 0, mismatches = 0, num_checks = 0;
  logic [33:0] exp_q[$];
  logic [21:0] vq[$];
  always #2 aclk = ~aclk;
  csv_core u_csv_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .op_valid, .op_ready, .op_kind,
    .op_data, .op_bit, .op_addr, .op_overflow, .prog_ready, .mem_addr, .mem_wdata, .mem_we,
    .mem_re, .mem_rdata, .mem_ready, .wait_state, .pop_data, .shift_result, .hw_int_valid,
    .hw_int_num, .vec_valid, .vec_addr, .halt_req, .run_req, .halted, .trst_n, .tap_tlr,
    .test_logic_reset);
  csv_mem_model u_csv_mem_model (.aclk, .aresetn, .mem_addr, .mem_wdata, .mem_we, .mem_re,
    .lat, .mem_rdata, .mem_ready, .prog_ready);
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic pa, pw;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    pa = 1;
    pw = 1;
    do begin
      @(posedge aclk);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end while (pa || pw);
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    exp_q.push_back({r, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
  endtask
  task automatic op(input csv_pkg::csv_op_e k, input logic [31:0] d,
    input logic [21:0] a = 22'h0, input logic [3:0] b = 4'h0, input logic ov = 1'b0);
    @(posedge aclk);
    lat <= 4'($random(seed)) & 4'h3;
    op_kind <= k;
    op_data <= d;
    op_addr <= a;
    op_bit <= b;
    op_overflow <= ov;
    op_valid <= 1;
    do @(posedge aclk); while (op_ready !== 1'b1);
    op_valid <= 0;
    do @(posedge aclk); while (op_ready !== 1'b1 && halted !== 1'b1);
  endtask
  task automatic hw(input logic [4:0] n);
    @(posedge aclk);
    hw_int_valid <= 1;
    hw_int_num <= n;
    @(posedge aclk);
    hw_int_valid <= 0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // Results from the bus and the vector port are matched in order against the notes.
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      chk(exp_q.pop_front(), {s_axi_bresp, 32'h0});
    end
    if (vec_valid === 1'b1) chk(vq.pop_front(), vec_addr);
    if (aresetn && (mem_we === 1'b1 || mem_re === 1'b1) && mem_ready === 1'b0) begin
      chk(1, wait_state);
    end
    // A fetch that program memory holds off must show up as a wait cycle.
    if (aresetn && prog_ready === 1'b0 && u_csv_core.r.busy === 1'b1
        && u_csv_core.r.phase == csv_pkg::PH_F1) begin
      chk(1, wait_state);
    end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    foreach (rst_regs[i]) rd(rst_regs[i], 0);
    rd(8'h40, 0, `CSV_RESP_SLVERR);
    wr(8'h40, 1, `CSV_RESP_SLVERR);
    done("reset");
    d0 = 16'($random(seed));
    d1 = 16'($random(seed));
    wr(`CSV_OFF_SP, 32'h0000FFFF);
    op(csv_pkg::OP_PUSH, d0);
    rd(`CSV_OFF_SP, 0);
    chk(22'h00FFFF, u_csv_mem_model.last_wa);
    chk(d0, u_csv_mem_model.mem[8'hFF]);
    op(csv_pkg::OP_PUSH, d1);
    op(csv_pkg::OP_POP, 0);
    chk(d1, pop_data);
    op(csv_pkg::OP_POP, 0);
    chk(d0, pop_data);
    rd(`CSV_OFF_SP, 32'h0000FFFF);
    op(csv_pkg::OP_ASP, 0);
    rd(`CSV_OFF_SP, 0);
    rd(`CSV_OFF_ST1, 1);
    op(csv_pkg::OP_ASP, 0);
    rd(`CSV_OFF_ST1, 0);
    done("stack");
    wr(`CSV_OFF_TREG, 32'h0000FFF3);
    foreach (kinds[i]) begin
      op(kinds[i], sh_in[i]);
      chk(sh_exp[i], shift_result);
    end
    op(csv_pkg::OP_LSR, 32'h4);
    rd(`CSV_OFF_ST0, 32'h4);
    op(csv_pkg::OP_BIT_TEST_INSTR, 32'h20, 0, 4'h5);
    rd(`CSV_OFF_ST0, 32'h5);
    op(csv_pkg::OP_BIT_TEST_INSTR, 32'h20, 0, 4'h6);
    rd(`CSV_OFF_ST0, 32'h4);
    op(csv_pkg::OP_NORMALIZE_INSTR, 32'h0);
    rd(`CSV_OFF_ST0, 32'h5);
    op(csv_pkg::OP_ALU, 32'h1, 0, 0, 1);
    rd(`CSV_OFF_ST0, 32'h3);
    op(csv_pkg::OP_ALU, 32'h0);
    rd(`CSV_OFF_ST0, 32'h7);
    wr(`CSV_OFF_ST0, 0);
    rd(`CSV_OFF_ST0, 0);
    done("flags");
    for (int n = 1; n <= 12; n++) begin
      base = n[0] ? `CSV_VEC_HIGH : `CSV_VEC_LOW;
      wr(`CSV_OFF_ST1, {n[0], 1'b0});
      vq.push_back(base + 22'(2 * (19 + n)));
      op(csv_pkg::OP_TRAP, n);
    end
    vq.push_back(22'hA);
    hw(5'd5);
    hw(5'd20);
    rd(`CSV_OFF_ISTAT, 32'h6);
    done("vectors");
    wr(`CSV_OFF_IMASK, 32'h2);
    chk(1, irq);
    @(posedge aclk);
    halt_req <= 1;
    @(posedge aclk);
    halt_req <= 0;
    repeat (2) @(posedge aclk);
    chk(1, halted);
    hw(5'd5);
    rd(`CSV_OFF_ISTAT, 32'hE);
    wr(`CSV_OFF_CTRL, 32'h1);
    chk(0, halted);
    wr(`CSV_OFF_ISTAT, 32'hE);
    chk(0, irq);
    done("halt");
    wr(`CSV_OFF_WADDR, 32'h30);
    wr(`CSV_OFF_WDATA, 32'hBEEF);
    wr(`CSV_OFF_WCTRL, 32'h3);
    op(csv_pkg::OP_STORE, 32'h1234, 22'h30);
    repeat (3) @(posedge aclk);
    chk(0, halted);
    op(csv_pkg::OP_STORE, 32'hBEEF, 22'h30);
    repeat (3) @(posedge aclk);
    chk(1, halted);
    chk(16'hBEEF, u_csv_mem_model.mem[8'h30]);
    wr(`CSV_OFF_IMASK, 32'h1);
    chk(1, irq);
    @(posedge aclk);
    run_req <= 1;
    @(posedge aclk);
    run_req <= 0;
    repeat (2) @(posedge aclk);
    chk(0, halted);
    wr(`CSV_OFF_ISTAT, 32'h1);
    chk(0, irq);
    done("watch");
    @(posedge aclk);
    trst_n <= 0;
    @(posedge aclk);
    chk(1, test_logic_reset);
    rd(`CSV_OFF_WCTRL, 0);
    rd(`CSV_OFF_IMASK, 32'h1);
    trst_n <= 1;
    wr(`CSV_OFF_WCTRL, 32'h3);
    tap_tlr <= 1;
    rd(`CSV_OFF_WCTRL, 0);
    tap_tlr <= 0;
    @(posedge aclk);
    chk(0, test_logic_reset);
    done("test reset");
    stop_test();
  end
endmodule
